// ===== shared/cnp_pkg.sv
package cnp_pkg;

  // Clock and event-time base
  localparam int CLK_PERIOD_NS   = 4;
  localparam int EVENT_UNIT_NS   = 1000000;
  localparam int MS_CYCLES       = EVENT_UNIT_NS / CLK_PERIOD_NS;
  localparam int NUM_RXCH        = 3;

  // Object indices and sub-indices
  localparam logic [15:0] IDX_ERR_BEHAV   = 16'h1029;
  localparam logic [15:0] IDX_SDO_SRV     = 16'h1200;
  localparam logic [15:0] IDX_RXCH_BASE   = 16'h1400;
  localparam logic [7:0]  SUB_COUNT       = 8'h00;
  localparam logic [7:0]  SUB_ERR_REACT   = 8'h01;
  localparam logic [7:0]  SUB_SDO_REQ     = 8'h01;
  localparam logic [7:0]  SUB_SDO_RSP     = 8'h02;
  localparam logic [7:0]  SUB_RX_ID       = 8'h01;
  localparam logic [7:0]  SUB_RX_TTYPE    = 8'h02;
  localparam logic [7:0]  SUB_RX_INHIBIT  = 8'h03;
  localparam logic [7:0]  SUB_RX_EVTIME   = 8'h05;

  // Entry counts and values after reset
  localparam logic [7:0]  ERR_ENTRY_COUNT  = 8'h01;
  localparam logic [7:0]  SDO_ENTRY_COUNT  = 8'h02;
  localparam logic [7:0]  RXCH_ENTRY_COUNT = 8'h02;
  localparam logic [7:0]  ERR_REACT_RST    = 8'h00;
  localparam logic [10:0] SDO_REQ_BASE     = 11'h600;
  localparam logic [10:0] SDO_RSP_BASE     = 11'h580;
  localparam logic [10:0] RXCH_ID_BASE [NUM_RXCH] = '{11'h200, 11'h300, 11'h400};
  localparam logic [NUM_RXCH-1:0] RXCH_INVALID_RST = 3'h6;
  localparam logic [7:0]  TTYPE_RST        = 8'hFF;
  localparam logic [15:0] INHIBIT_RST      = 16'h0000;
  localparam logic [15:0] EVTIME_RST       = 16'h0000;

  // Field meanings
  localparam int          ID_VALID_BIT     = 31;
  localparam int          ID_FRAME_BIT     = 29;
  localparam logic [7:0]  TTYPE_SYNC_MAX   = 8'hF0;
  localparam logic [7:0]  TTYPE_EVT_MIN    = 8'hFE;
  localparam logic [7:0]  REACT_PREOP      = 8'h00;
  localparam logic [7:0]  REACT_NONE       = 8'h01;
  localparam logic [7:0]  REACT_STOP       = 8'h02;
  localparam logic [15:0] FAULT_CODE_RX1   = 16'h202A;

  // Abort codes
  localparam logic [31:0] ABORT_READ_ONLY  = 32'h06010002;
  localparam logic [31:0] ABORT_NO_OBJECT  = 32'h06020000;
  localparam logic [31:0] ABORT_NO_SUB     = 32'h06090011;
  localparam logic [31:0] ABORT_BAD_VALUE  = 32'h06090030;

  typedef enum logic [1:0] {
    CNP_PREOP   = 2'b00,
    CNP_OPER    = 2'b01,
    CNP_STOPPED = 2'b10
  } cnp_nmt_t;

  typedef struct packed {
    logic        wr;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } cnp_od_req_t;

  typedef struct packed {
    logic        ack;
    logic        abort;
    logic [31:0] abort_code;
    logic [31:0] rdata;
  } cnp_od_rsp_t;

  typedef struct packed {
    logic busoff;
    logic guarding;
    logic heartbeat;
    logic sync_loss;
    logic rx_length;
  } cnp_faults_t;

  typedef struct packed {
    logic        invalid;
    logic [10:0] rx_channel_identifier;
    logic [7:0]  ttype;
    logic [15:0] inhibit;
    logic [15:0] evtime;
  } cnp_chan_cfg_t;

  // Identifier word: frame bit, bit 30 and bits 11..28 always zero
  function automatic logic [31:0] cnp_id_word(input logic invalid, input logic [10:0] id);
    cnp_id_word = {invalid, 1'h0, 1'h0, 18'h00000, id};
  endfunction

endpackage

// ===== design/cnp_rx_chan.sv
`timescale 1ns/10ps
module cnp_rx_chan (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire cnp_pkg::cnp_chan_cfg_t cfg,
  input  wire logic                   run,
  input  wire logic                   tick,
  input  wire logic                   frame_valid,
  input  wire logic [10:0]            frame_id,
  input  wire logic                   sync_pulse,
  output logic                        apply_ff,
  output logic                        timeout_ff
);
  import cnp_pkg::*;

  logic        hit;
  logic        evt_mode;
  logic        sync_mode;
  logic        monitor;
  logic        pend_ff;
  logic        nxt_pend;
  logic        nxt_apply;
  logic [15:0] ms_cnt_ff;
  logic [15:0] nxt_ms_cnt;
  logic        expired_ff;
  logic        nxt_expired;
  logic        nxt_timeout;

  always_comb begin
    hit       = frame_valid && !cfg.invalid && (frame_id == cfg.rx_channel_identifier);
    evt_mode  = cfg.ttype >= TTYPE_EVT_MIN;
    sync_mode = cfg.ttype <= TTYPE_SYNC_MAX;
    // Event time zero means no monitoring
    monitor   = run && !cfg.invalid && (cfg.evtime != EVTIME_RST);
    nxt_apply = (hit && evt_mode) || (sync_pulse && pend_ff && sync_mode);
    // A frame in the SYNC cycle waits for the next SYNC
    nxt_pend  = sync_mode && (hit || (pend_ff && !sync_pulse));
    nxt_ms_cnt  = ms_cnt_ff;
    nxt_expired = expired_ff;
    nxt_timeout = 1'h0;
    if (!monitor || hit) begin
      nxt_ms_cnt  = 16'h0000;
      nxt_expired = 1'h0;
    end else if (tick && !expired_ff) begin
      nxt_ms_cnt = ms_cnt_ff + 16'h0001;
      if (nxt_ms_cnt >= cfg.evtime) begin
        nxt_expired = 1'h1;
        nxt_timeout = 1'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_ff    <= 1'h0;
      apply_ff   <= 1'h0;
      ms_cnt_ff  <= 16'h0000;
      expired_ff <= 1'h0;
      timeout_ff <= 1'h0;
    end else begin
      pend_ff    <= nxt_pend;
      apply_ff   <= nxt_apply;
      ms_cnt_ff  <= nxt_ms_cnt;
      expired_ff <= nxt_expired;
      timeout_ff <= nxt_timeout;
    end
  end

  sequence s_sync_frame;
    hit && sync_mode && !sync_pulse;
  endsequence

  sequence s_next_sync;
    sync_pulse && sync_mode;
  endsequence

  AST_EVT_APPLY: assert property (@(posedge clk) disable iff (!rstn)
    hit && evt_mode |=> apply_ff)
    else $error("event-driven frame not applied");

  AST_SYNC_APPLY: assert property (@(posedge clk) disable iff (!rstn)
    s_sync_frame ##1 s_next_sync |=> apply_ff)
    else $error("synchronous frame not applied on SYNC");

  AST_DISABLED_IGNORED: assert property (@(posedge clk) disable iff (!rstn)
    cfg.invalid && !pend_ff |=> !apply_ff)
    else $error("disabled channel applied data");

  AST_TIMEOUT: assert property (@(posedge clk) disable iff (!rstn)
    timeout_ff |-> $past(monitor) && $past(tick) && ($past(ms_cnt_ff) + 16'h0001 >= $past(cfg.evtime)))
    else $error("timeout raised before event time");
endmodule

// ===== design/cnp_comm_params.sv
`timescale 1ns/10ps
// Overview of operation
// - Code 0: Operational drops to Pre-Operational
// - Code 1: fault leaves state unchanged
// - Code 2: fault forces Stopped state
// - Bus-off, guarding, heartbeat, SYNC, length trigger reaction
// - SDO request identifier is 1536 plus address
// - SDO response identifier is 1408 plus address
// - SDO identifiers read-only, derived from address
// - SDO words read valid and 11-bit format
// - Identifier in low eleven bits, bits 11..30 zero
// - Channel identifiers default 0x200/0x300/0x400 plus node
// - Only identifier, type, event time act
// - Channel identifier writes are accepted unless bit 29 is set
// - Transmission type defaults to 255
// - Top identifier bit set disables the channel
// - Types 254/255 per frame; up to 240 per SYNC
// - Missing frame within event time raises fault
// - Inhibit time stored, no effect
module cnp_comm_params #(
  parameter int TICK_CYCLES = cnp_pkg::MS_CYCLES
) (
  input  wire logic                         clk,
  input  wire logic                         rstn,
  input  wire logic [6:0]                   node_addr,
  input  wire logic                         od_req_valid,
  input  wire cnp_pkg::cnp_od_req_t         od_req,
  output cnp_pkg::cnp_od_rsp_t              od_rsp_ff,
  input  wire logic                         nmt_cmd_valid,
  input  wire cnp_pkg::cnp_nmt_t            nmt_cmd,
  input  wire cnp_pkg::cnp_faults_t         comm_fault,
  input  wire logic                         rx_frame_valid,
  input  wire logic [10:0]                  rx_frame_id,
  input  wire logic                         sync_pulse,
  output cnp_pkg::cnp_nmt_t                 nmt_state_ff,
  output logic [cnp_pkg::NUM_RXCH-1:0]      rx_apply_ff,
  output logic [cnp_pkg::NUM_RXCH-1:0]      rx_timeout_ff,
  output logic                              fault_strobe_ff,
  output logic [15:0]                       fault_code_ff
);
  import cnp_pkg::*;

  localparam int TICK_W = $clog2(TICK_CYCLES);

  // Millisecond prescaler shared by all channels
  logic [TICK_W-1:0] tick_cnt_ff;
  logic [TICK_W-1:0] nxt_tick_cnt;
  logic              tick_ff;
  logic              nxt_tick;

  always_comb begin
    nxt_tick     = 1'h0;
    nxt_tick_cnt = tick_cnt_ff + {{(TICK_W-1){1'h0}}, 1'h1};
    if (tick_cnt_ff == TICK_W'(TICK_CYCLES - 1)) begin
      nxt_tick_cnt = '0;
      nxt_tick     = 1'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_ff <= '0;
      tick_ff     <= 1'h0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
      tick_ff     <= nxt_tick;
    end
  end

  // Object dictionary state. Address-dependent defaults cannot be loaded
  // under async reset, so they are loaded on the first edge after release.
  logic                           init_done_ff;
  logic [7:0]                     err_react_ff;
  logic [7:0]                     nxt_err_react;
  cnp_chan_cfg_t [NUM_RXCH-1:0]   chan_ff;
  cnp_chan_cfg_t [NUM_RXCH-1:0]   nxt_chan;
  cnp_od_rsp_t                    nxt_rsp;
  logic [15:0]                    rx_off;
  logic                           is_rxch;
  logic [1:0]                     rx_sel;
  logic [10:0]                    sdo_req_id;
  logic [10:0]                    sdo_rsp_id;

  always_comb begin
    sdo_req_id    = SDO_REQ_BASE + {4'h0, node_addr};
    sdo_rsp_id    = SDO_RSP_BASE + {4'h0, node_addr};
    rx_off        = od_req.index - IDX_RXCH_BASE;
    is_rxch       = rx_off < 16'(NUM_RXCH);
    rx_sel        = rx_off[1:0];
    nxt_err_react = err_react_ff;
    nxt_chan      = chan_ff;
    nxt_rsp       = '0;
    if (!init_done_ff) begin
      for (int ch = 0; ch < NUM_RXCH; ch++) begin
        nxt_chan[ch].invalid = RXCH_INVALID_RST[ch];
        nxt_chan[ch].rx_channel_identifier  = RXCH_ID_BASE[ch] + {4'h0, node_addr};
        nxt_chan[ch].ttype   = TTYPE_RST;
        nxt_chan[ch].inhibit = INHIBIT_RST;
        nxt_chan[ch].evtime  = EVTIME_RST;
      end
    end else if (od_req_valid) begin
      nxt_rsp.ack = 1'h1;
      case (od_req.index)
        IDX_ERR_BEHAV: begin
          if (od_req.sub == SUB_COUNT) begin
            if (od_req.wr) begin
              nxt_rsp.abort      = 1'h1;
              nxt_rsp.abort_code = ABORT_READ_ONLY;
            end else begin
              nxt_rsp.rdata = {24'h000000, ERR_ENTRY_COUNT};
            end
          end else if (od_req.sub == SUB_ERR_REACT) begin
            if (!od_req.wr) begin
              nxt_rsp.rdata = {24'h000000, err_react_ff};
            end else if (od_req.wdata[7:0] > REACT_STOP) begin
              nxt_rsp.abort      = 1'h1;
              nxt_rsp.abort_code = ABORT_BAD_VALUE;
            end else begin
              nxt_err_react = od_req.wdata[7:0];
            end
          end else begin
            nxt_rsp.abort      = 1'h1;
            nxt_rsp.abort_code = ABORT_NO_SUB;
          end
        end
        IDX_SDO_SRV: begin
          if (od_req.sub > SDO_ENTRY_COUNT) begin
            nxt_rsp.abort      = 1'h1;
            nxt_rsp.abort_code = ABORT_NO_SUB;
          end else if (od_req.wr) begin
            nxt_rsp.abort      = 1'h1;
            nxt_rsp.abort_code = ABORT_READ_ONLY;
          end else if (od_req.sub == SUB_SDO_REQ) begin
            nxt_rsp.rdata = cnp_id_word(1'h0, sdo_req_id);
          end else if (od_req.sub == SUB_SDO_RSP) begin
            nxt_rsp.rdata = cnp_id_word(1'h0, sdo_rsp_id);
          end else begin
            nxt_rsp.rdata = {24'h000000, SDO_ENTRY_COUNT};
          end
        end
        default: begin
          if (!is_rxch) begin
            nxt_rsp.abort      = 1'h1;
            nxt_rsp.abort_code = ABORT_NO_OBJECT;
          end else begin
            case (od_req.sub)
              SUB_COUNT: begin
                if (od_req.wr) begin
                  nxt_rsp.abort      = 1'h1;
                  nxt_rsp.abort_code = ABORT_READ_ONLY;
                end else begin
                  nxt_rsp.rdata = {24'h000000, RXCH_ENTRY_COUNT};
                end
              end
              SUB_RX_ID: begin
                if (!od_req.wr) begin
                  nxt_rsp.rdata = cnp_id_word(chan_ff[rx_sel].invalid, chan_ff[rx_sel].rx_channel_identifier);
                end else if (od_req.wdata[ID_FRAME_BIT]) begin
                  nxt_rsp.abort      = 1'h1;
                  nxt_rsp.abort_code = ABORT_BAD_VALUE;
                end else begin
                  nxt_chan[rx_sel].invalid = od_req.wdata[ID_VALID_BIT];
                  nxt_chan[rx_sel].rx_channel_identifier  = od_req.wdata[10:0];
                end
              end
              SUB_RX_TTYPE: begin
                if (!od_req.wr) begin
                  nxt_rsp.rdata = {24'h000000, chan_ff[rx_sel].ttype};
                end else if (od_req.wdata[7:0] > TTYPE_SYNC_MAX && od_req.wdata[7:0] < TTYPE_EVT_MIN) begin
                  nxt_rsp.abort      = 1'h1;
                  nxt_rsp.abort_code = ABORT_BAD_VALUE;
                end else begin
                  nxt_chan[rx_sel].ttype = od_req.wdata[7:0];
                end
              end
              SUB_RX_INHIBIT: begin
                if (od_req.wr) begin
                  nxt_chan[rx_sel].inhibit = od_req.wdata[15:0];
                end else begin
                  nxt_rsp.rdata = {16'h0000, chan_ff[rx_sel].inhibit};
                end
              end
              SUB_RX_EVTIME: begin
                if (od_req.wr) begin
                  nxt_chan[rx_sel].evtime = od_req.wdata[15:0];
                end else begin
                  nxt_rsp.rdata = {16'h0000, chan_ff[rx_sel].evtime};
                end
              end
              default: begin
                nxt_rsp.abort      = 1'h1;
                nxt_rsp.abort_code = ABORT_NO_SUB;
              end
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      init_done_ff <= 1'h0;
      err_react_ff <= ERR_REACT_RST;
      chan_ff      <= '0;
      od_rsp_ff    <= '0;
    end else begin
      init_done_ff <= 1'h1;
      err_react_ff <= nxt_err_react;
      chan_ff      <= nxt_chan;
      od_rsp_ff    <= nxt_rsp;
    end
  end

  // Network-management state; a fault beats a master command in the same cycle
  logic     any_fault;
  cnp_nmt_t nxt_nmt;

  always_comb begin
    any_fault = |comm_fault;
    nxt_nmt   = nmt_state_ff;
    if (any_fault) begin
      case (err_react_ff)
        REACT_PREOP: begin
          if (nmt_state_ff == CNP_OPER) begin
            nxt_nmt = CNP_PREOP;
          end
        end
        REACT_NONE: begin
          nxt_nmt = nmt_state_ff;
        end
        REACT_STOP: begin
          nxt_nmt = CNP_STOPPED;
        end
        default: begin
          nxt_nmt = nmt_state_ff;
        end
      endcase
    end else if (nmt_cmd_valid) begin
      nxt_nmt = nmt_cmd;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nmt_state_ff <= CNP_PREOP;
    end else begin
      nmt_state_ff <= nxt_nmt;
    end
  end

  // Receive channels; the whole channel entry reaches them, inhibit time unused
  for (genvar g = 0; g < NUM_RXCH; g++) begin : g_chan
    cnp_rx_chan u_chan (
      .clk         (clk),
      .rstn        (rstn),
      .cfg         (chan_ff[g]),
      .run         (init_done_ff && (nmt_state_ff == CNP_OPER)),
      .tick        (tick_ff),
      .frame_valid (rx_frame_valid),
      .frame_id    (rx_frame_id),
      .sync_pulse  (sync_pulse),
      .apply_ff    (rx_apply_ff[g]),
      .timeout_ff  (rx_timeout_ff[g])
    );
  end

  // Fault code report; lowest channel wins if several expire together
  logic        nxt_fault_strobe;
  logic [15:0] nxt_fault_code;

  always_comb begin
    nxt_fault_strobe = 1'h0;
    nxt_fault_code   = fault_code_ff;
    for (int ch = NUM_RXCH - 1; ch >= 0; ch--) begin
      if (rx_timeout_ff[ch]) begin
        nxt_fault_strobe = 1'h1;
        nxt_fault_code   = FAULT_CODE_RX1 + 16'(ch);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fault_strobe_ff <= 1'h0;
      fault_code_ff   <= 16'h0000;
    end else begin
      fault_strobe_ff <= nxt_fault_strobe;
      fault_code_ff   <= nxt_fault_code;
    end
  end

  AST_REACT_PREOP: assert property (@(posedge clk) disable iff (!rstn)
    any_fault && err_react_ff == REACT_PREOP && nmt_state_ff == CNP_OPER |=> nmt_state_ff == CNP_PREOP)
    else $error("fault did not drop to Pre-Operational");

  AST_REACT_NONE: assert property (@(posedge clk) disable iff (!rstn)
    any_fault && err_react_ff == REACT_NONE |=> $stable(nmt_state_ff))
    else $error("fault changed state with reaction code one");

  AST_REACT_STOP: assert property (@(posedge clk) disable iff (!rstn)
    any_fault && err_react_ff == REACT_STOP |=> nmt_state_ff == CNP_STOPPED)
    else $error("fault did not force Stopped");

  AST_SDO_REQ_ID: assert property (@(posedge clk) disable iff (!rstn)
    init_done_ff && od_req_valid && !od_req.wr && od_req.index == IDX_SDO_SRV && od_req.sub == SUB_SDO_REQ
    |=> od_rsp_ff.ack && od_rsp_ff.rdata == 32'h0000_0600 + 32'($past(node_addr)))
    else $error("SDO request identifier wrong");

  AST_SDO_RSP_ID: assert property (@(posedge clk) disable iff (!rstn)
    init_done_ff && od_req_valid && !od_req.wr && od_req.index == IDX_SDO_SRV && od_req.sub == SUB_SDO_RSP
    |=> od_rsp_ff.ack && od_rsp_ff.rdata == 32'h0000_0580 + 32'($past(node_addr)))
    else $error("SDO response identifier wrong");

  AST_RO_WRITE: assert property (@(posedge clk) disable iff (!rstn)
    init_done_ff && od_req_valid && od_req.wr && od_req.sub == SUB_COUNT
    |=> od_rsp_ff.abort && $stable(chan_ff) && $stable(err_react_ff))
    else $error("read-only write not refused");

  AST_FRAME_BIT: assert property (@(posedge clk) disable iff (!rstn)
    init_done_ff && od_req_valid && od_req.wr && is_rxch && od_req.sub == SUB_RX_ID && od_req.wdata[ID_FRAME_BIT]
    |=> od_rsp_ff.abort && od_rsp_ff.abort_code == ABORT_BAD_VALUE && $stable(chan_ff))
    else $error("29-bit identifier write not refused");

  AST_DEFAULTS: assert property (@(posedge clk) disable iff (!rstn)
    !init_done_ff |=> chan_ff[1].rx_channel_identifier == 11'h300 + {4'h0, $past(node_addr)} && chan_ff[2].ttype == 8'hFF)
    else $error("channel defaults not loaded");
endmodule

// ===== tb/cnp_master_model.sv
`timescale 1ns/10ps
module cnp_master_model (
  input  wire logic                 clk,
  input  wire cnp_pkg::cnp_od_rsp_t od_rsp,
  output cnp_pkg::cnp_od_req_t      od_req,
  output logic                      od_req_valid
);
  import cnp_pkg::*;

  initial begin
    od_req_valid = 1'b0;
    od_req       = '0;
  end

  // One request in flight; answer read 1 ns after the taking edge
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                      input logic [31:0] wd, output cnp_od_rsp_t rsp);
    @(posedge clk);
    #1;
    od_req_valid = 1'b1;
    od_req       = '{wr, idx, sub, wd};
    @(posedge clk);
    #1;
    od_req_valid = 1'b0;
    // Released bus must not keep the old request visible
    od_req       = ~od_req;
    rsp          = od_rsp;
  endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/10ps
module tb;
  import cnp_pkg::*;
  localparam logic [6:0] NODE = 7'h05;
  logic        clk;
  logic        rstn;
  logic        nmt_cmd_valid;
  cnp_nmt_t    nmt_cmd;
  cnp_faults_t comm_fault;
  logic        rx_frame_valid;
  logic [10:0] rx_frame_id;
  logic        sync_pulse;
  logic        od_req_valid;
  cnp_od_req_t od_req;
  cnp_od_rsp_t od_rsp;
  cnp_nmt_t    nmt_state;
  logic [2:0]  apply;
  logic [2:0]  tmo;
  logic        fstb;
  logic [15:0] fcode;
  int          errors;
  int          n_tests;
  int          cyc;

  cnp_comm_params #(.TICK_CYCLES(4)) uut (
    .clk(clk), .rstn(rstn), .node_addr(NODE), .od_req_valid(od_req_valid), .od_req(od_req),
    .od_rsp_ff(od_rsp), .nmt_cmd_valid(nmt_cmd_valid), .nmt_cmd(nmt_cmd), .comm_fault(comm_fault),
    .rx_frame_valid(rx_frame_valid), .rx_frame_id(rx_frame_id), .sync_pulse(sync_pulse),
    .nmt_state_ff(nmt_state), .rx_apply_ff(apply), .rx_timeout_ff(tmo),
    .fault_strobe_ff(fstb), .fault_code_ff(fcode)
  );

  cnp_master_model m (.clk(clk), .od_rsp(od_rsp), .od_req(od_req), .od_req_valid(od_req_valid));

  task automatic finish_test();
    if (errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                     input logic [31:0] wd, input logic ab, input logic [31:0] ev);
    cnp_od_rsp_t r;
    m.xfer(wr, idx, sub, wd, r);
    chk({r.ack, r.abort, r.abort ? r.abort_code : r.rdata}, {1'b1, ab, ev});
  endtask

  // All event inputs as one-cycle pulses
  task automatic drive(input logic nv, input cnp_nmt_t s, input cnp_faults_t f,
                       input logic fv, input logic [10:0] id, input logic sy);
    @(posedge clk);
    #1;
    nmt_cmd_valid  = nv;
    nmt_cmd        = s;
    comm_fault     = f;
    rx_frame_valid = fv;
    rx_frame_id    = id;
    sync_pulse     = sy;
    @(posedge clk);
    #1;
    nmt_cmd_valid  = 1'b0;
    comm_fault     = '0;
    rx_frame_valid = 1'b0;
    rx_frame_id    = ~id;
    sync_pulse     = 1'b0;
  endtask

  task automatic t_defaults();
    acc(0, IDX_ERR_BEHAV, SUB_COUNT, 0, 0, 32'h1);
    acc(0, IDX_ERR_BEHAV, SUB_ERR_REACT, 0, 0, 32'h0);
    acc(0, IDX_SDO_SRV, SUB_COUNT, 0, 0, 32'h2);
    acc(0, IDX_SDO_SRV, SUB_SDO_REQ, 0, 0, 32'h600 + NODE);
    acc(0, IDX_SDO_SRV, SUB_SDO_RSP, 0, 0, 32'h580 + NODE);
    for (int c = 0; c < 3; c++) begin
      acc(0, IDX_RXCH_BASE + 16'(c), SUB_COUNT, 0, 0, 32'h2);
      acc(0, IDX_RXCH_BASE + 16'(c), SUB_RX_ID, 0, 0, {c != 0, 20'h0, RXCH_ID_BASE[c] + 11'(NODE)});
      acc(0, IDX_RXCH_BASE + 16'(c), SUB_RX_TTYPE, 0, 0, 32'hFF);
      acc(0, IDX_RXCH_BASE + 16'(c), SUB_RX_EVTIME, 0, 0, 32'h0);
    end
  endtask

  task automatic t_refusals();
    acc(1, IDX_SDO_SRV, SUB_SDO_REQ, 32'h7FF, 1, ABORT_READ_ONLY);
    acc(1, IDX_SDO_SRV, SUB_SDO_RSP, 32'h7FF, 1, ABORT_READ_ONLY);
    acc(1, IDX_ERR_BEHAV, SUB_COUNT, 32'h5, 1, ABORT_READ_ONLY);
    acc(1, IDX_RXCH_BASE, SUB_COUNT, 32'h5, 1, ABORT_READ_ONLY);
    acc(0, IDX_SDO_SRV, SUB_SDO_REQ, 0, 0, 32'h600 + NODE);
    acc(0, IDX_ERR_BEHAV, SUB_COUNT, 0, 0, 32'h1);
    acc(0, 16'h1300, SUB_COUNT, 0, 1, ABORT_NO_OBJECT);
    acc(1, IDX_RXCH_BASE, SUB_RX_ID, 32'h2000_0123, 1, ABORT_BAD_VALUE);
    acc(0, IDX_RXCH_BASE, SUB_RX_ID, 0, 0, 32'h205);
    acc(1, IDX_RXCH_BASE, SUB_RX_ID, 32'h4FFF_F123, 0, 0);
    acc(0, IDX_RXCH_BASE, SUB_RX_ID, 0, 0, 32'h123);
    acc(1, IDX_RXCH_BASE, SUB_RX_INHIBIT, 32'h1234, 0, 0);
    acc(0, IDX_RXCH_BASE, SUB_RX_INHIBIT, 0, 0, 32'h1234);
    acc(0, IDX_RXCH_BASE, 8'h04, 0, 1, ABORT_NO_SUB);
    acc(1, IDX_RXCH_BASE, SUB_RX_TTYPE, 32'hF1, 1, ABORT_BAD_VALUE);
    acc(1, IDX_ERR_BEHAV, SUB_ERR_REACT, 32'h3, 1, ABORT_BAD_VALUE);
  endtask

  task automatic t_react();
    cnp_nmt_t e;
    for (int c = 0; c < 3; c++) begin
      acc(1, IDX_ERR_BEHAV, SUB_ERR_REACT, c, 0, 0);
      e = (c == 0) ? CNP_PREOP : (c == 1) ? CNP_OPER : CNP_STOPPED;
      for (int f = 0; f < 5; f++) begin
        drive(1, CNP_OPER, '0, 0, 0, 0);
        drive(0, CNP_OPER, cnp_faults_t'(5'h10 >> f), 0, 0, 0);
        chk(34'(nmt_state), 34'(e));
      end
    end
    acc(1, IDX_ERR_BEHAV, SUB_ERR_REACT, 0, 0, 0);
    drive(1, CNP_STOPPED, '0, 0, 0, 0);
    drive(0, CNP_OPER, 5'h01, 0, 0, 0);
    chk(34'(nmt_state), 34'(CNP_STOPPED));
  endtask

  task automatic t_rx();
    logic [7:0] tt [4];
    tt = '{8'hFF, 8'hFE, 8'h00, 8'hF0};
    foreach (tt[i]) begin
      acc(1, IDX_RXCH_BASE, SUB_RX_TTYPE, {24'h0, tt[i]}, 0, 0);
      drive(0, CNP_PREOP, '0, 1, 11'h123, 0);
      chk(34'(apply), (tt[i] > TTYPE_SYNC_MAX) ? 34'h1 : 34'h0);
      if (tt[i] <= TTYPE_SYNC_MAX) begin
        drive(0, CNP_PREOP, '0, 0, 0, 1);
        chk(34'(apply), 34'h1);
      end
    end
    // SYNC on the edge right after the frame
    @(posedge clk);
    #1;
    rx_frame_valid = 1'b1;
    rx_frame_id    = 11'h123;
    @(posedge clk);
    #1;
    rx_frame_valid = 1'b0;
    sync_pulse     = 1'b1;
    @(posedge clk);
    #1;
    sync_pulse     = 1'b0;
    chk(34'(apply), 34'h1);
    acc(1, IDX_RXCH_BASE, SUB_RX_TTYPE, 32'hFF, 0, 0);
    drive(0, CNP_PREOP, '0, 1, 11'h305, 0);
    chk(34'(apply), 34'h0);
    acc(1, IDX_RXCH_BASE + 16'h1, SUB_RX_ID, 32'h305, 0, 0);
    drive(0, CNP_PREOP, '0, 1, 11'h305, 0);
    chk(34'(apply), 34'h2);
    acc(1, IDX_RXCH_BASE, SUB_RX_ID, 32'h8000_0123, 0, 0);
    drive(0, CNP_PREOP, '0, 1, 11'h123, 0);
    chk(34'(apply), 34'h0);
    acc(1, IDX_RXCH_BASE, SUB_RX_ID, 32'h123, 0, 0);
  endtask

  task automatic t_timeout();
    acc(1, IDX_RXCH_BASE, SUB_RX_EVTIME, 32'h1, 0, 0);
    drive(1, CNP_OPER, '0, 0, 0, 0);
    for (int i = 0; i < 40 && tmo[0] !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk(34'(tmo), 34'h1);
    @(posedge clk);
    #1;
    chk({fstb, fcode}, {1'b1, FAULT_CODE_RX1});
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Hang guard, far above the couple of hundred cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    errors = 0;
    n_tests = 0;
    cyc = 0;
    rstn = 1'b0;
    nmt_cmd_valid = 1'b0;
    nmt_cmd = CNP_PREOP;
    comm_fault = '0;
    rx_frame_valid = 1'b0;
    rx_frame_id = '0;
    sync_pulse = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    rstn = 1'b1;
    repeat (2) @(posedge clk);
    t_defaults();
    t_refusals();
    t_react();
    t_rx();
    t_timeout();
    finish_test();
  end
endmodule
